// File: visr_pkg.sv
package visr_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ          = 10_000_000;
   localparam int SPIKE_NS        = 32;
   localparam int SPIKE_CYC_RAW   = (SPIKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int SPIKE_CYC       = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
   localparam int STD_SCL_HZ      = 100_000;
   localparam int FAST_SCL_HZ     = 400_000;
   localparam int SCL_QUARTER_CYC = (CLK_HZ + 4 * FAST_SCL_HZ - 1) / (4 * FAST_SCL_HZ);
   localparam int RESPONSE_SCL    = 27;
   localparam logic [2:0] STRAP_SETTLE = 3'h6;
   localparam logic [3:0] BYTE_BITS    = 4'h8;

   // ****************************************
   // Device register map
   // ****************************************
   localparam logic [7:0] REG_VCODE_IDX  = 8'h00;
   localparam logic [7:0] REG_CTRL_IDX   = 8'h01;
   localparam logic [6:0] VCODE_RST      = 7'h32;
   localparam logic       VCODE_PAR_RST  = ~^VCODE_RST;
   localparam int         VCODE_PAR_BIT  = 7;
   localparam int         CTRL_INT_BIT   = 7;
   localparam int         CTRL_PMASK_BIT = 4;
   localparam int         CTRL_LL_BIT    = 3;
   localparam int         CTRL_PROT_BIT  = 0;
   localparam logic [7:0] CTRL_RST       = 8'h09;
   localparam logic [7:0] CTRL_USED_MASK = 8'h99;
   localparam logic [6:0] DEV_ADDR_BASE  = 7'h2c;
   localparam int         STRAP_BIT      = 1;

   // ****************************************
   // Controller registers on APB
   // ****************************************
   localparam logic [11:0] HOST_CMD_OFS   = 12'h000;
   localparam logic [11:0] HOST_STAT_OFS  = 12'h004;
   localparam logic [11:0] HOST_RDATA_OFS = 12'h008;
   localparam logic [11:0] HOST_TADDR_OFS = 12'h00c;
   localparam int CMD_GO_BIT     = 0;
   localparam int CMD_READ_BIT   = 1;
   localparam int CMD_IDX_LSB    = 8;
   localparam int CMD_DATA_LSB   = 16;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_DONE_BIT  = 1;
   localparam int STAT_NACK_BIT  = 2;

   typedef enum logic [3:0] {
      D_IDLE, D_ADDR, D_ADDR_ACK, D_IDX, D_IDX_ACK,
      D_WDATA, D_DATA_ACK, D_RDATA, D_IGNORE
   } visr_dstate_t;

   typedef enum logic [1:0] {
      H_IDLE, H_START, H_BIT, H_STOP
   } visr_hstate_t;

endpackage

// File: visr_i2c_if.sv
`timescale 1ns/100ps
`default_nettype none
interface visr_i2c_if;
   logic host_scl_out;
   logic host_scl_oe;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // Wired-AND of the open-drain drivers
   assign scl = ~(host_scl_oe & ~host_scl_out);
   assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

   modport device (input scl, sda, output dev_sda_out, dev_sda_oe);
   modport host   (input scl, sda,
                   output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe);
endinterface
`default_nettype wire

// File: visr_pin_filter.sv
`timescale 1ns/100ps
`default_nettype none
module visr_pin_filter #(
   parameter int           W   = 2,
   parameter logic [W-1:0] RST = '1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } visr_filt_t;

   visr_filt_t r;
   visr_filt_t next_r;

   // ****************************************
   // Three stages, change taken once 2nd and 3rd agree
   // ****************************************
   always_comb begin
      next_r    = r;
      next_r.s1 = din;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      next_r.q  = (~(r.s2 ^ r.s3) & r.s2) | ((r.s2 ^ r.s3) & r.q);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         r <= {RST, RST, RST, RST};
      end else begin
         r <= next_r;
      end
   end

   assign dout = r.q;
endmodule
`default_nettype wire

// File: visr_dev_end.sv
// Notes on behaviour
// - Slave works at 100 and 400 kbit/s
// - Spikes of 32 ns never become edges
// - Address compared after START, ACK bit 9
// - Wrong address: no ACK, wait next START
// - Direction bit: 0 write, 1 read
// - Voltage reg: parity bit 7, code reset 0110010
// - Master sets bit 7 to XNOR of code
// - Bad parity: no ACK, register unchanged
// - Master retries a refused write; host end only sets the NACK status bit and stops
// - Voltage read returns stored parity too
// - Good byte acknowledged and loaded
// - Read shifts 8 bits, then idle
// - Master re-reads if result doubtful; host end reads each register once per command
// - New command applied within 27 SCL periods
// - Control bit 7: 0 external, 1 internal
// - Control bit 4 masks protection on change
// - Control bit 3: 0 PFM, 1 fixed PWM
// - Control bit 0: 0 auto-recover, 1 latch-off
`timescale 1ns/100ps
`default_nettype none
module visr_dev_end
   import visr_pkg::*;
#(
   parameter logic [6:0] ADDR_BASE = DEV_ADDR_BASE
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   visr_i2c_if.device      bus,
   input  wire logic       addr_strap,
   output logic      [7:0] output_voltage_code,
   output logic            internal_mode,
   output logic            protect_mask_on_change,
   output logic            light_load_pulse_select,
   output logic            protection_latch_off
);
   typedef struct packed {
      visr_dstate_t st;
      logic [3:0]   bitn;
      logic [7:0]   sh;
      logic         rw;
      logic [7:0]   idx;
      logic [7:0]   vcode;
      logic [7:0]   ctrl;
      logic         sda_oe;
      logic [2:0]   strap_cnt;
      logic         strap;
      logic         scl_d;
      logic         sda_d;
   } visr_dev_t;

   visr_dev_t  r;
   visr_dev_t  next_r;
   logic [2:0] pins_f;
   logic       scl_f;
   logic       sda_f;
   logic       strap_f;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;
   logic [6:0] own_addr;
   logic       par_ok;
   logic [7:0] rd_val;

   // ****************************************
   // Pin conditioning
   // ****************************************
   // glitch filter on pins
   visr_pin_filter #(
      .W   (3),
      .RST (3'h7)
   ) u_filt (
      .clk_sys (clk_sys),
      .rst     (rst),
      .din     ({addr_strap, bus.sda, bus.scl}),
      .dout    (pins_f)
   );

   assign scl_f   = pins_f[0];
   assign sda_f   = pins_f[1];
   assign strap_f = pins_f[2];

   assign scl_rise   = scl_f & ~r.scl_d;
   assign scl_fall   = ~scl_f & r.scl_d;
   assign start_seen = scl_f & r.scl_d & r.sda_d & ~sda_f;
   assign stop_seen  = scl_f & r.scl_d & ~r.sda_d & sda_f;

   // ****************************************
   // Address, parity and read value
   // ****************************************
   always_comb begin
      own_addr            = ADDR_BASE;
      own_addr[STRAP_BIT] = r.strap;
   end

   assign par_ok = (r.sh[VCODE_PAR_BIT] == ~^r.sh[6:0]);

   assign rd_val = (r.idx == REG_CTRL_IDX) ? r.ctrl : r.vcode;

   // ****************************************
   // Protocol engine
   // ****************************************
   always_comb begin
      next_r       = r;
      next_r.scl_d = scl_f;
      next_r.sda_d = sda_f;
      if (r.strap_cnt != STRAP_SETTLE) begin
         next_r.strap_cnt = r.strap_cnt + 3'h1;
         next_r.strap     = strap_f;
      end
      if (stop_seen) begin
         next_r.st     = D_IDLE;
         next_r.sda_oe = 1'b0;
      end else if (start_seen) begin
         next_r.st     = D_ADDR;
         next_r.bitn   = 4'h0;
         next_r.sda_oe = 1'b0;
      end else begin
         case (r.st)
            D_ADDR, D_IDX, D_WDATA: begin
               if (scl_rise) begin
                  next_r.sh   = {r.sh[6:0], sda_f};
                  next_r.bitn = r.bitn + 4'h1;
               end else if (scl_fall && r.bitn == BYTE_BITS) begin
                  next_r.bitn = 4'h0;
                  next_r.st   = D_IGNORE;
                  if (r.st == D_ADDR && r.sh[7:1] == own_addr) begin
                     next_r.rw     = r.sh[0];
                     next_r.sda_oe = 1'b1;
                     next_r.st     = D_ADDR_ACK;
                  end else if (r.st == D_IDX && r.sh <= REG_CTRL_IDX) begin
                     next_r.idx    = r.sh;
                     next_r.sda_oe = 1'b1;
                     next_r.st     = D_IDX_ACK;
                  end else if (r.st == D_WDATA && par_ok) begin
                     if (r.idx == REG_CTRL_IDX) begin
                        next_r.ctrl = r.sh & CTRL_USED_MASK;
                     end else begin
                        next_r.vcode = r.sh;
                     end
                     next_r.sda_oe = 1'b1;
                     next_r.st     = D_DATA_ACK;
                  end
               end
            end
            D_ADDR_ACK, D_IDX_ACK, D_DATA_ACK: begin
               if (scl_fall) begin
                  next_r.sda_oe = 1'b0;
                  next_r.st     = D_WDATA;
                  if (r.st == D_ADDR_ACK) begin
                     if (r.rw) begin
                        next_r.st     = D_RDATA;
                        next_r.sh     = rd_val;
                        next_r.sda_oe = ~rd_val[7];
                     end else begin
                        next_r.st = D_IDX;
                     end
                  end
               end
            end
            D_RDATA: begin
               if (scl_fall) begin
                  if (r.bitn == BYTE_BITS - 4'h1) begin
                     next_r.sda_oe = 1'b0;
                     next_r.bitn   = 4'h0;
                     next_r.st     = D_IGNORE;
                  end else begin
                     next_r.sh     = {r.sh[6:0], 1'b0};
                     next_r.sda_oe = ~r.sh[6];
                     next_r.bitn   = r.bitn + 4'h1;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         r.st        <= D_IDLE;
         r.bitn      <= 4'h0;
         r.sh        <= 8'h00;
         r.rw        <= 1'b0;
         r.idx       <= REG_VCODE_IDX;
         r.vcode     <= {VCODE_PAR_RST, VCODE_RST};
         r.ctrl      <= CTRL_RST;
         r.sda_oe    <= 1'b0;
         r.strap_cnt <= 3'h0;
         r.strap     <= 1'b0;
         r.scl_d     <= 1'b1;
         r.sda_d     <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign bus.dev_sda_out = 1'b0;
   assign bus.dev_sda_oe  = r.sda_oe;

   assign output_voltage_code     = r.vcode;
   assign internal_mode           = r.ctrl[CTRL_INT_BIT];
   assign protect_mask_on_change  = r.ctrl[CTRL_PMASK_BIT];
   assign light_load_pulse_select = r.ctrl[CTRL_LL_BIT];
   assign protection_latch_off    = r.ctrl[CTRL_PROT_BIT];
endmodule
`default_nettype wire

// File: visr_host_end.sv
// Our own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module visr_host_end
   import visr_pkg::*;
#(
   parameter int         QUARTER   = SCL_QUARTER_CYC,
   parameter logic [6:0] TADDR_RST = DEV_ADDR_BASE
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   visr_i2c_if.host         bus,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   typedef struct packed {
      visr_hstate_t st;
      logic [7:0]   div;
      logic [1:0]   q;
      logic [3:0]   bitn;
      logic [2:0]   byten;
      logic [7:0]   sh;
      logic         rd;
      logic [7:0]   idx;
      logic [7:0]   wdat;
      logic [7:0]   rdat;
      logic [6:0]   taddr;
      logic         busy;
      logic         done;
      logic         nack;
      logic         scl_oe;
      logic         sda_oe;
      logic [31:0]  prdata;
   } visr_host_t;

   visr_host_t r;
   visr_host_t next_r;
   logic       sda_f;
   logic       tick;
   logic       rx_byte;
   logic [7:0] byte_val;
   logic       acc_wr;

   visr_pin_filter #(
      .W   (1),
      .RST (1'b1)
   ) u_filt (
      .clk_sys (clk_sys),
      .rst     (rst),
      .din     (bus.sda),
      .dout    (sda_f)
   );

   assign tick    = (r.div == 8'(QUARTER - 1));
   assign rx_byte = (r.byten == 3'h4);
   assign acc_wr  = psel & penable & pwrite;
   always_comb begin
      case (r.byten)
         3'h0:    byte_val = {r.taddr, 1'b0};
         3'h1:    byte_val = r.idx;
         3'h2:    byte_val = r.wdat;
         default: byte_val = {r.taddr, 1'b1};
      endcase
   end

   // ****************************************
   // APB slave and bit engine
   // ****************************************
   always_comb begin
      next_r     = r;
      next_r.div = tick ? 8'h00 : r.div + 8'h01;
      if (psel && !penable) begin
         case (paddr)
            HOST_STAT_OFS:  next_r.prdata = {29'h0, r.nack, r.done, r.busy};
            HOST_RDATA_OFS: next_r.prdata = {24'h0, r.rdat};
            HOST_TADDR_OFS: next_r.prdata = {25'h0, r.taddr};
            default:        next_r.prdata = 32'h0;
         endcase
      end
      if (acc_wr && paddr == HOST_TADDR_OFS) begin
         next_r.taddr = pwdata[6:0];
      end
      if (acc_wr && paddr == HOST_CMD_OFS && pwdata[CMD_GO_BIT] && !r.busy) begin
         next_r.busy  = 1'b1;
         next_r.done  = 1'b0;
         next_r.nack  = 1'b0;
         next_r.rd    = pwdata[CMD_READ_BIT];
         next_r.idx   = pwdata[CMD_IDX_LSB +: 8];
         next_r.wdat  = pwdata[CMD_DATA_LSB +: 8];
         next_r.byten = 3'h0;
         next_r.q     = 2'h0;
         next_r.div   = 8'h00;
         next_r.st    = H_START;
      end else if (tick && r.st != H_IDLE) begin
         next_r.q = r.q + 2'h1;
         case (r.st)
            H_START: begin
               case (r.q)
                  2'h0: begin
                     next_r.scl_oe = 1'b1;
                     next_r.sda_oe = 1'b0;
                  end
                  2'h1: next_r.scl_oe = 1'b0;
                  2'h2: next_r.sda_oe = 1'b1;
                  default: begin
                     next_r.scl_oe = 1'b1;
                     next_r.sh     = byte_val;
                     next_r.bitn   = 4'h0;
                     next_r.st     = H_BIT;
                  end
               endcase
            end
            H_BIT: begin
               case (r.q)
                  2'h0: next_r.scl_oe = 1'b1;
                  2'h1: begin
                     next_r.sda_oe = (r.bitn != BYTE_BITS) && !rx_byte
                                     && !r.sh[7];
                  end
                  2'h2: next_r.scl_oe = 1'b0;
                  default: begin
                     next_r.sh   = {r.sh[6:0], sda_f};
                     next_r.bitn = r.bitn + 4'h1;
                     if (r.bitn == BYTE_BITS) begin
                        next_r.sh    = r.sh;
                        next_r.bitn  = 4'h0;
                        next_r.byten = r.byten + 3'h1;
                        if (!rx_byte && sda_f) begin
                           next_r.nack = 1'b1;
                           next_r.st   = H_STOP;
                        end else if (r.byten == 3'h1 && r.rd) begin
                           next_r.byten = 3'h3;
                           next_r.st    = H_START;
                        end else if (r.byten == 3'h2 || rx_byte) begin
                           next_r.rdat = rx_byte ? r.sh : r.rdat;
                           next_r.st   = H_STOP;
                        end else begin
                           next_r.sh = (r.byten == 3'h0) ? r.idx : byte_val;
                           if (r.byten == 3'h1) begin
                              next_r.sh = r.wdat;
                           end
                        end
                     end
                  end
               endcase
            end
            default: begin
               case (r.q)
                  2'h0: next_r.scl_oe = 1'b1;
                  2'h1: next_r.sda_oe = 1'b1;
                  2'h2: next_r.scl_oe = 1'b0;
                  default: begin
                     next_r.sda_oe = 1'b0;
                     next_r.busy   = 1'b0;
                     next_r.done   = 1'b1;
                     next_r.st     = H_IDLE;
                  end
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         r       <= '0;
         r.st    <= H_IDLE;
         r.taddr <= TADDR_RST;
      end else begin
         r <= next_r;
      end
   end

   assign bus.host_scl_out = 1'b0;
   assign bus.host_scl_oe  = r.scl_oe;
   assign bus.host_sda_out = 1'b0;
   assign bus.host_sda_oe  = r.sda_oe;
   assign prdata  = r.prdata;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
endmodule
`default_nettype wire

// File: visr_chk.sv
`timescale 1ns/100ps
`default_nettype none
module visr_chk
   import visr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_BASE
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe
);
   // ****************************************
   // Bus phase tracking
   // ****************************************
   logic       prev_scl;
   logic       prev_sda;
   logic       busy;
   logic       rd;
   logic       match;
   logic [3:0] bitcnt;
   logic [3:0] nb;
   logic [1:0] bytecnt;
   logic [7:0] sr;
   logic       start;
   logic       stop;
   logic       rise;
   logic       ack_slot;
   logic       dev_turn;

   assign start    = prev_scl & scl & prev_sda & ~sda;
   assign stop     = prev_scl & scl & ~prev_sda & sda;
   assign rise     = ~prev_scl & scl & busy;
   assign nb       = (bitcnt == 4'h9) ? 4'h1 : bitcnt + 4'h1;
   assign ack_slot = rise & (nb == 4'h9);
   assign dev_turn = rd & match & ((bytecnt != 2'h0) | (bitcnt == 4'h9));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prev_scl <= 1'b1;
         prev_sda <= 1'b1;
         busy     <= 1'b0;
         rd       <= 1'b0;
         match    <= 1'b0;
         bitcnt   <= 4'h0;
         bytecnt  <= 2'h0;
         sr       <= 8'h00;
      end else begin
         prev_scl <= scl;
         prev_sda <= sda;
         if (start) begin
            busy    <= 1'b1;
            bitcnt  <= 4'h0;
            bytecnt <= 2'h0;
            rd      <= 1'b0;
         end else if (stop) begin
            busy <= 1'b0;
         end else if (rise) begin
            bitcnt <= nb;
            if (nb != 4'h9) sr <= {sr[6:0], sda};
            if (bitcnt == 4'h9 && bytecnt != 2'h3) bytecnt <= bytecnt + 2'h1;
            if (ack_slot && bytecnt == 2'h0) begin
               rd    <= sr[0];
               match <= (sr[7:1] == DEV_ADDR);
            end
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   AST_DEV_SDA_SCL_LOW: assert property (
      $changed(dev_sda_oe) |-> !scl)
      else $error("device moved SDA while SCL high");
   AST_IDLE_NO_DRIVE: assert property (
      !busy |-> !dev_sda_oe)
      else $error("device drives SDA on idle bus");
   AST_ADDR_ACK: assert property (
      ack_slot && bytecnt == 2'h0 |-> dev_sda_oe == (sr[7:1] == DEV_ADDR))
      else $error("address acknowledge wrong");
   AST_MASTER_BITS: assert property (
      rise && nb != 4'h9 && !dev_turn |-> !dev_sda_oe)
      else $error("device drives SDA during master bits");
   AST_IDX_ACK: assert property (
      ack_slot && bytecnt == 2'h1 && !rd && match && dev_sda_oe
      |-> sr <= 8'h01)
      else $error("out of range index acknowledged");
   AST_PARITY_ACK: assert property (
      ack_slot && bytecnt == 2'h2 && !rd && dev_sda_oe
      |-> sr[7] == ~^sr[6:0])
      else $error("byte with bad parity acknowledged");
   AST_READ_RELEASE: assert property (
      ack_slot && dev_turn |-> !dev_sda_oe [*4])
      else $error("device holds SDA after read byte");
   AST_HOST_ACK_RELEASE: assert property (
      ack_slot && !dev_turn |-> !host_sda_oe)
      else $error("master drives SDA in acknowledge slot");
   AST_DEV_HOLD_BOUND: assert property (
      $rose(dev_sda_oe) |-> ##[1:300] !dev_sda_oe)
      else $error("device holds SDA too long");
endmodule
`default_nettype wire

// File: vid_i2c_slave_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module vid_i2c_slave_regs_tb
   import visr_pkg::*;
   ;
   localparam logic [6:0] DEV_A = DEV_ADDR_BASE | (7'h01 << STRAP_BIT);
   typedef struct {logic kind; logic [31:0] val;} visr_note_t;
   logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, res_v;
   logic        internal_mode, protect_mask_on_change;
   logic        light_load_pulse_select, protection_latch_off;
   logic [11:0] paddr, dev_st;
   logic [11:0] last_st = 'x;
   logic [31:0] pwdata, prdata, got, res_d;
   logic [7:0]  output_voltage_code, exp_v, exp_c;
   int          err_count, checked;
   visr_note_t  note_q[$];

   visr_i2c_if i2c ();
   visr_dev_end u_visr_dev_end (.clk_sys(clk_sys), .rst(rst),
      .bus(i2c.device), .addr_strap(1'b1),
      .output_voltage_code(output_voltage_code),
      .internal_mode(internal_mode),
      .protect_mask_on_change(protect_mask_on_change),
      .light_load_pulse_select(light_load_pulse_select),
      .protection_latch_off(protection_latch_off));
   visr_host_end #(.TADDR_RST(DEV_A)) u_visr_host_end (
      .clk_sys(clk_sys), .rst(rst), .bus(i2c.host), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   visr_chk #(.DEV_ADDR(DEV_A)) u_visr_chk (.clk_sys(clk_sys),
      .rst(rst), .scl(i2c.scl), .sda(i2c.sda),
      .host_sda_oe(i2c.host_sda_oe), .dev_sda_oe(i2c.dev_sda_oe));

   // ****************************************
   // Checking
   // ****************************************
   function automatic logic [11:0] st_of(input logic [7:0] v,
                                         input logic [7:0] c);
      return {v, c[CTRL_INT_BIT], c[CTRL_PMASK_BIT], c[CTRL_LL_BIT],
              c[CTRL_PROT_BIT]};
   endfunction

   task automatic note(input logic k, input logic [31:0] v);
      visr_note_t n;
      n.kind = k;
      n.val = v;
      note_q.push_back(n);
   endtask

   task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic cmp_state(input logic [11:0] e, input logic [11:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic take(input logic k, input logic [31:0] g);
      visr_note_t n;
      n = '{k, 'x};
      if (note_q.size() != 0) n = note_q.pop_front();
      if (n.kind !== k) cmp_word({31'h0, n.kind}, {31'h0, k});
      else if (k) cmp_state(n.val[11:0], g[11:0]);
      else cmp_word(n.val, g);
   endtask

   assign dev_st = {output_voltage_code, internal_mode,
                    protect_mask_on_change, light_load_pulse_select,
                    protection_latch_off};

   always @(posedge clk_sys) begin
      if (dev_st !== last_st) begin
         last_st = dev_st;
         take(1'b1, {20'h0, dev_st});
      end
      if (res_v === 1'b1) begin
         res_v <= 1'b0;
         take(1'b0, res_d);
      end
   end

   // ****************************************
   // Drivers
   // ****************************************
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic rep);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      got = prdata;
      cmp_word(32'h0, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
      res_d <= prdata;
      res_v <= rep;
   endtask

   task automatic op(input logic rd, input logic [7:0] idx,
                     input logic [7:0] d, input logic nack);
      apb(1'b1, HOST_CMD_OFS, {8'h00, d, idx, 6'h00, rd, 1'b1}, 1'b0);
      got = 32'h1;
      while (got[STAT_BUSY_BIT] !== 1'b0)
         apb(1'b0, HOST_STAT_OFS, 32'h0, 1'b0);
      note(1'b0, {29'h0, nack, 2'b10});
      apb(1'b0, HOST_STAT_OFS, 32'h0, 1'b1);
      repeat (2) @(posedge clk_sys);
      cmp_word(32'h0, 32'(note_q.size()));
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                     input logic ok);
      logic [11:0] old;
      old = st_of(exp_v, exp_c);
      if (ok && idx == REG_VCODE_IDX) exp_v = d;
      if (ok && idx == REG_CTRL_IDX) exp_c = d & CTRL_USED_MASK;
      if (st_of(exp_v, exp_c) !== old)
         note(1'b1, {20'h0, st_of(exp_v, exp_c)});
      op(1'b0, idx, d, ~ok);
   endtask

   task automatic rdchk(input logic [7:0] idx);
      op(1'b1, idx, 8'h00, 1'b0);
      note(1'b0, {24'h0, (idx == REG_CTRL_IDX) ? exp_c : exp_v});
      apb(1'b0, HOST_RDATA_OFS, 32'h0, 1'b1);
   endtask

   task automatic test_done;
      if (note_q.size() != 0) err_count++;
      if (err_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (60000) @(posedge clk_sys);
      err_count++;
      test_done;
   end

   initial begin
      logic [6:0] c7;
      logic [6:0] tbl [4];
      tbl = '{7'h00, 7'h19, 7'h66, 7'h09};
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      res_v = 1'b0;
      res_d = 32'h0;
      err_count = 0;
      checked = 0;
      exp_v = {VCODE_PAR_RST, VCODE_RST};
      exp_c = CTRL_RST;
      note(1'b1, {20'h0, st_of(exp_v, exp_c)});
      void'($urandom(32'h92eb));
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rdchk(REG_VCODE_IDX);
      rdchk(REG_CTRL_IDX);
      for (int i = 0; i < 8; i++) begin
         c7 = i[0] ? tbl[i / 2] : 7'($urandom);
         wr({7'h0, i[0]}, {~^c7, c7}, 1'b1);
         rdchk({7'h0, i[0]});
      end
      for (int i = 0; i < 2; i++) begin
         c7 = 7'($urandom);
         wr({7'h0, i[0]}, {^c7, c7}, 1'b0);
         rdchk({7'h0, i[0]});
      end
      wr(8'h02, 8'h80, 1'b0);
      apb(1'b1, HOST_TADDR_OFS, {25'h0, DEV_A ^ 7'h04}, 1'b0);
      note(1'b0, {25'h0, DEV_A ^ 7'h04});
      apb(1'b0, HOST_TADDR_OFS, 32'h0, 1'b1);
      wr(REG_VCODE_IDX, 8'h80, 1'b0);
      apb(1'b1, HOST_TADDR_OFS, {25'h0, DEV_A}, 1'b0);
      rdchk(REG_VCODE_IDX);
      note(1'b0, 32'h0);
      apb(1'b0, 12'h010, 32'h0, 1'b1);
      note(1'b0, 32'h0);
      apb(1'b0, HOST_CMD_OFS, 32'h0, 1'b1);
      repeat (4) @(posedge clk_sys);
      test_done;
   end
endmodule
`default_nettype wire
